// *** logic/pmseq_regs.vh ***
// register offsets, field positions, reset values and timing counts of the mode sequencer
// assumes the includer, verilog-2005 or SystemVerilog, uses these by macro name
`ifndef PMSEQ_REGS_VH
`define PMSEQ_REGS_VH
// register indices on the plain port
`define PMSEQ_ADDR_W         4
`define PMSEQ_REG_CTRL       4'h0
`define PMSEQ_REG_STATUS     4'h1
`define PMSEQ_REG_PG_MASK    4'h2
`define PMSEQ_REG_INT_MASK   4'h3
`define PMSEQ_REG_INT_FLAGS  4'h4
`define PMSEQ_REG_PG_STAT    4'h5
// control fields
`define PMSEQ_CTRL_SOFT_RST  0
`define PMSEQ_CTRL_SLEEP     6
// status fields
`define PMSEQ_STAT_LOADED_N  7
// supply count (buck_a, buck_b, led_boost, five linear regulators)
`define PMSEQ_NSUP           8
// led_boost bit position in supply vectors
`define PMSEQ_SUP_LED_BOOST  2
// interrupt source count
`define PMSEQ_NINT           16
// reset values
`define PMSEQ_PG_MASK_RST    8'hFF
`define PMSEQ_INT_MASK_RST   16'h0000
// power-good threshold in percent of programmed voltage
`define PMSEQ_PG_PCT         90
// sequencing step time in us, clock in MHz, derived cycle count
`define PMSEQ_SEQ_STEP_US    100
`define PMSEQ_CLK_MHZ        50
`define PMSEQ_SEQ_STEP_CYC   (`PMSEQ_SEQ_STEP_US * `PMSEQ_CLK_MHZ)
// hardware reset deglitch in us and cycles
`define PMSEQ_DEGLITCH_US    5000
`define PMSEQ_DEGLITCH_CYC   (`PMSEQ_DEGLITCH_US * `PMSEQ_CLK_MHZ)
// reset time in us (1 ms/nF with 1 nF default) and cycles
`define PMSEQ_RESET_US       1000
`define PMSEQ_RESET_CYC      (`PMSEQ_RESET_US * `PMSEQ_CLK_MHZ)
// mode codes
`define PMSEQ_ST_NOPOWER     3'h0
`define PMSEQ_ST_LOAD        3'h1
`define PMSEQ_ST_ENABLE      3'h2
`define PMSEQ_ST_SEQ         3'h3
`define PMSEQ_ST_RESET       3'h4
`define PMSEQ_ST_PGCHK       3'h5
`define PMSEQ_ST_NORMAL      3'h6
`define PMSEQ_ST_SLEEP       3'h7
`endif

// *** logic/pmseq_top.v ***
// operating-mode sequencer: power-up, fault handling, host reset and interrupt pin
// assumes analog comparator levels arrive asynchronously and are synchronised here;
// registers are reached over a plain address/strobe port with read data one cycle later
//
// Notes on behaviour
// - supply faults below 90 percent, boost overvoltage
// - unmasked fault gives sleep or fresh power-up
// - fault comparators blanked during initial power-up
// - thermal fault sleeps until all power removed
// - hardware reset input low drives host reset
// - soft reset bit gives timed host reset
// - each supply fault individually maskable
// - masks on every monitored parameter
// - interrupt on any unmasked parameter change (flags here are cleared while host reset is low)
// - sequencer and interrupt monitor listed inputs
// - all blocks off below undervoltage lockout
// - load defaults once internal rails active
// - power path on, clear loaded flag, enable
// - enable holds reset, floats interrupt, blanks comparators
// - wait system sense above threshold, then sequence
// - sequencing turns supplies on, starts reset timer
// - bucks enabled only with their pin inputs
// - first linear regulator enabled with bucks
// - power-good masks reset to masked
// - timer expiry enters power-good check
// - check state fault sleeps, else normal
//
// The register offsets and the address-and-strobe port were left to the implementer.
`include "pmseq_regs.vh"
module pmseq_top #(
  parameter SEQ_STEP_CYC = `PMSEQ_SEQ_STEP_CYC,
  parameter DEGLITCH_CYC = `PMSEQ_DEGLITCH_CYC,
  parameter RESET_CYC    = `PMSEQ_RESET_CYC
) (
  // clock and reset from the undervoltage lockout
  input  wire                       clk,
  input  wire                       rst_n,
  // power sense (asynchronous levels)
  input  wire                       uvlo_ok_in,
  input  wire                       rails_ok_in,
  input  wire                       sys_sense_in,
  input  wire                       thermal_fault_in,
  input  wire                       hw_reset_in_n,
  input  wire                       gp_pin_a,
  input  wire                       gp_pin_b,
  input  wire [`PMSEQ_NSUP-1:0]     sup_below_pg_in,
  input  wire                       led_boost_ovp_in,
  input  wire [7:0]                 other_status_in,
  // register port
  input  wire [`PMSEQ_ADDR_W-1:0]   reg_addr,
  input  wire [15:0]                reg_wdata,
  input  wire                       reg_write,
  input  wire                       reg_read,
  output reg  [15:0]                reg_rdata,
  // supply and pin controls
  output reg                        power_path_en,
  output reg  [`PMSEQ_NSUP-1:0]     sup_en,
  output reg                        pg_comp_en,
  output reg                        host_reset_output_n,
  output reg                        int_out,
  output reg                        int_oe,
  output reg  [2:0]                 mode
);

  // synchroniser stage widths
  localparam NS = 13 + `PMSEQ_NSUP;

  reg [NS-1:0]                s1_reg;
  reg [NS-1:0]                s2_reg;
  reg [2:0]                   state_reg;
  reg [2:0]                   state_next;
  reg [31:0]                  tmr_reg;
  reg [31:0]                  deg_reg;
  reg                         hw_held_reg;
  reg                         therm_sleep_reg;
  reg                         loaded_n_reg;
  reg                         soft_rst_reg;
  reg                         soft_sleep_reg;
  reg [`PMSEQ_NSUP-1:0]       pg_mask_reg;
  reg [`PMSEQ_NINT-1:0]       int_mask_reg;
  reg [`PMSEQ_NINT-1:0]       int_flags_reg;
  reg [`PMSEQ_NINT-1:0]       mon_prev_reg;

  wire                        uvlo_ok   = s2_reg[0];
  wire                        rails_ok  = s2_reg[1];
  wire                        sys_ok    = s2_reg[2];
  wire                        therm     = s2_reg[3];
  wire                        hw_rst_n  = s2_reg[4];
  wire                        gpa       = s2_reg[5];
  wire                        gpb       = s2_reg[6];
  wire                        boost_ovp = s2_reg[7];
  wire [4:0]                  oth       = s2_reg[12:8];
  wire [`PMSEQ_NSUP-1:0]      below     = s2_reg[NS-1:13];
  wire [`PMSEQ_NSUP-1:0]      pg_fault;
  wire                        pg_trip;
  wire [`PMSEQ_NINT-1:0]      mon;
  wire                        hw_long;

  // fault per supply: below threshold, but boost uses overvoltage
  assign pg_fault = {below[`PMSEQ_NSUP-1:`PMSEQ_SUP_LED_BOOST+1], boost_ovp,
                     below[`PMSEQ_SUP_LED_BOOST-1:0]};
  // masked supplies never trip; comparators off means no trip
  assign pg_trip  = pg_comp_en & |(pg_fault & ~pg_mask_reg);
  // monitored parameters for the interrupt controller
  assign mon      = {pg_fault, therm, sys_ok, uvlo_ok, oth};
  assign hw_long  = (deg_reg >= DEGLITCH_CYC);

  // two-flop synchronisers on every analog level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= {NS{1'b0}};
      s2_reg <= {NS{1'b0}};
    end else begin
      s1_reg <= {sup_below_pg_in, other_status_in[4:0], led_boost_ovp_in, gp_pin_b, gp_pin_a,
                 hw_reset_in_n, thermal_fault_in, sys_sense_in, rails_ok_in, uvlo_ok_in};
      s2_reg <= s1_reg;
    end
  end

  // next mode
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `PMSEQ_ST_NOPOWER: begin
        if (uvlo_ok && rails_ok)
          state_next = `PMSEQ_ST_LOAD;
      end
      `PMSEQ_ST_LOAD:   state_next = `PMSEQ_ST_ENABLE;
      `PMSEQ_ST_ENABLE: begin
        if (sys_ok)
          state_next = `PMSEQ_ST_SEQ;
      end
      `PMSEQ_ST_SEQ: begin
        if (tmr_reg >= 3 * SEQ_STEP_CYC)
          state_next = `PMSEQ_ST_RESET;
      end
      `PMSEQ_ST_RESET: begin
        if (tmr_reg >= RESET_CYC && !hw_held_reg)
          state_next = `PMSEQ_ST_PGCHK;
      end
      `PMSEQ_ST_PGCHK: begin
        if (pg_trip)
          state_next = `PMSEQ_ST_SLEEP;
        else
          state_next = `PMSEQ_ST_NORMAL;
      end
      `PMSEQ_ST_NORMAL: begin
        if (therm || !sys_ok || soft_sleep_reg)
          state_next = `PMSEQ_ST_SLEEP;
        else if (pg_trip)
          state_next = `PMSEQ_ST_NOPOWER;
        else if (soft_rst_reg || hw_held_reg)
          state_next = `PMSEQ_ST_RESET;
      end
      `PMSEQ_ST_SLEEP: begin
        if (!therm_sleep_reg && sys_ok && !soft_sleep_reg)
          state_next = `PMSEQ_ST_ENABLE;
      end
      default: state_next = `PMSEQ_ST_NOPOWER;
    endcase
    // below lockout everything returns to no power
    if (!uvlo_ok)
      state_next = `PMSEQ_ST_NOPOWER;
  end

  // mode register, timers and flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= `PMSEQ_ST_NOPOWER;
      tmr_reg         <= 32'h00000000;
      deg_reg         <= 32'h00000000;
      hw_held_reg     <= 1'b0;
      therm_sleep_reg <= 1'b0;
      loaded_n_reg    <= 1'b1;
    end else begin
      state_reg <= state_next;
      // timer restarts on every mode change
      if (state_next != state_reg)
        tmr_reg <= 32'h00000000;
      else
        tmr_reg <= tmr_reg + 32'h00000001;
      // deglitch the hardware reset input
      if (hw_rst_n)
        deg_reg <= 32'h00000000;
      else if (!hw_long)
        deg_reg <= deg_reg + 32'h00000001;
      hw_held_reg <= hw_long & !hw_rst_n;
      if (state_next == `PMSEQ_ST_NOPOWER)
        therm_sleep_reg <= 1'b0;
      else if (state_reg == `PMSEQ_ST_NORMAL && therm)
        therm_sleep_reg <= 1'b1;
      if (state_reg == `PMSEQ_ST_NOPOWER)
        loaded_n_reg <= 1'b1;
      else if (state_reg == `PMSEQ_ST_LOAD)
        loaded_n_reg <= 1'b0;
    end
  end

  // registers written by software; defaults reload on load and hardware reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_mask_reg    <= `PMSEQ_PG_MASK_RST;
      int_mask_reg   <= `PMSEQ_INT_MASK_RST;
      soft_rst_reg   <= 1'b0;
      soft_sleep_reg <= 1'b0;
    end else if (state_reg == `PMSEQ_ST_LOAD || hw_held_reg) begin
      pg_mask_reg    <= `PMSEQ_PG_MASK_RST;
      int_mask_reg   <= `PMSEQ_INT_MASK_RST;
      soft_rst_reg   <= 1'b0;
      soft_sleep_reg <= 1'b0;
    end else begin
      if (state_reg == `PMSEQ_ST_RESET)
        soft_rst_reg <= 1'b0;
      if (state_reg == `PMSEQ_ST_ENABLE)
        soft_sleep_reg <= 1'b0;
      if (reg_write) begin
        case (reg_addr)
          `PMSEQ_REG_CTRL: begin
            soft_rst_reg   <= reg_wdata[`PMSEQ_CTRL_SOFT_RST];
            soft_sleep_reg <= reg_wdata[`PMSEQ_CTRL_SLEEP];
          end
          `PMSEQ_REG_PG_MASK:  pg_mask_reg  <= reg_wdata[`PMSEQ_NSUP-1:0];
          `PMSEQ_REG_INT_MASK: int_mask_reg <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // sticky interrupt flags on unmasked change; set beats write-one-to-clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_prev_reg  <= {`PMSEQ_NINT{1'b0}};
      int_flags_reg <= {`PMSEQ_NINT{1'b0}};
    end else begin
      mon_prev_reg <= mon;
      if (!host_reset_output_n)
        int_flags_reg <= {`PMSEQ_NINT{1'b0}};              // ignored during host reset
      else
        int_flags_reg <= (int_flags_reg &
                          ~((reg_write && reg_addr == `PMSEQ_REG_INT_FLAGS) ? reg_wdata
                                                               : {`PMSEQ_NINT{1'b0}}))
                         | ((mon ^ mon_prev_reg) & ~int_mask_reg);
    end
  end

  // outputs decoded from mode, all registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_path_en       <= 1'b0;
      sup_en              <= {`PMSEQ_NSUP{1'b0}};
      pg_comp_en          <= 1'b0;
      host_reset_output_n <= 1'b0;
      int_out             <= 1'b0;
      int_oe              <= 1'b0;
      mode                <= `PMSEQ_ST_NOPOWER;
    end else begin
      mode          <= state_reg;
      power_path_en <= (state_reg != `PMSEQ_ST_NOPOWER) &&
                       (state_reg != `PMSEQ_ST_LOAD);
      // supplies on from sequencing to normal; bucks gated by their pins
      if (state_reg == `PMSEQ_ST_SEQ || state_reg == `PMSEQ_ST_RESET ||
          state_reg == `PMSEQ_ST_PGCHK || state_reg == `PMSEQ_ST_NORMAL) begin
        sup_en[0] <= gpa;
        sup_en[1] <= gpb;
        sup_en[2] <= 1'b0;                                 // boost always held off
        sup_en[3] <= 1'b1;                                 // with the bucks
        sup_en[`PMSEQ_NSUP-1:4] <= {(`PMSEQ_NSUP-4){tmr_reg >= SEQ_STEP_CYC ||
                                    state_reg != `PMSEQ_ST_SEQ}};
      end else
        sup_en <= {`PMSEQ_NSUP{1'b0}};
      // comparators blanked until the check state
      pg_comp_en <= (state_next == `PMSEQ_ST_PGCHK) || (state_next == `PMSEQ_ST_NORMAL);
      // host reset low unless checking or normal and no hardware reset
      host_reset_output_n <= ((state_next == `PMSEQ_ST_PGCHK) ||
                              (state_next == `PMSEQ_ST_NORMAL)) && !hw_held_reg;
      int_out <= 1'b0;
      int_oe  <= host_reset_output_n && (state_reg == `PMSEQ_ST_NORMAL) &&
                 (|int_flags_reg);
    end
  end

  // read data one cycle after the read strobe, zero otherwise
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_read) begin
      case (reg_addr)
        `PMSEQ_REG_CTRL:      reg_rdata <= {9'h000, soft_sleep_reg, 5'h00, soft_rst_reg};
        `PMSEQ_REG_STATUS:    reg_rdata <= {8'h00, loaded_n_reg, 4'h0, state_reg};
        `PMSEQ_REG_PG_MASK:   reg_rdata <= {8'h00, pg_mask_reg};
        `PMSEQ_REG_INT_MASK:  reg_rdata <= int_mask_reg;
        `PMSEQ_REG_INT_FLAGS: reg_rdata <= int_flags_reg;
        `PMSEQ_REG_PG_STAT:   reg_rdata <= {8'h00, pg_fault};
        default:              reg_rdata <= 16'h0000;
      endcase
    end else
      reg_rdata <= 16'h0000;
  end

endmodule // pmseq_top

// *** verif/pmseq_top_asserts.sv ***
// concurrent checks on the mode sequencer ports, bound into its top module
// assumes the shared header for mode codes and register indices
`include "pmseq_regs.vh"
module pmseq_chk #(
  parameter DEGLITCH_CYC = 8
) (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // watched inputs
  input wire        uvlo_ok_in,
  input wire        hw_reset_in_n,
  input wire        gp_pin_b,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_write,
  // watched outputs
  input wire [7:0]  sup_en,
  input wire        pg_comp_en,
  input wire        host_reset_output_n,
  input wire        int_oe,
  input wire [2:0]  mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // cycles the hardware reset input has been held low, saturating
  int hold_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hold_cnt <= 0;
    else if (hw_reset_in_n) hold_cnt <= 0;
    else if (hold_cnt < 1000) hold_cnt <= hold_cnt + 1;
  end
  property p_enable_quiet;
    mode == `PMSEQ_ST_ENABLE |-> !host_reset_output_n && !int_oe && !pg_comp_en;
  endproperty
  a_enable_quiet: assert property (p_enable_quiet)
    else $error("enable mode outputs wrong");
  property p_enable_exit;
    mode == `PMSEQ_ST_ENABLE ##1 mode != `PMSEQ_ST_ENABLE |-> mode == `PMSEQ_ST_SEQ;
  endproperty
  a_enable_exit: assert property (p_enable_exit)
    else $error("enable left to wrong mode");
  property p_seq_exit;
    mode == `PMSEQ_ST_SEQ ##1 mode != `PMSEQ_ST_SEQ |-> mode == `PMSEQ_ST_RESET;
  endproperty
  a_seq_exit: assert property (p_seq_exit)
    else $error("sequencing left to wrong mode");
  property p_reset_exit;
    mode == `PMSEQ_ST_RESET ##1 mode != `PMSEQ_ST_RESET |-> mode == `PMSEQ_ST_PGCHK;
  endproperty
  a_reset_exit: assert property (p_reset_exit)
    else $error("reset left to wrong mode");
  property p_check_step;
    mode == `PMSEQ_ST_PGCHK |=> mode == `PMSEQ_ST_NORMAL || mode == `PMSEQ_ST_SLEEP;
  endproperty
  a_check_step: assert property (p_check_step)
    else $error("check mode not followed by normal or sleep");
  property p_blanked;
    mode <= `PMSEQ_ST_SEQ |-> !pg_comp_en;
  endproperty
  a_blanked: assert property (p_blanked)
    else $error("comparators on during power-up");
  property p_uvlo_off;
    (!uvlo_ok_in) [*6] |-> mode == `PMSEQ_ST_NOPOWER && sup_en == 8'h00;
  endproperty
  a_uvlo_off: assert property (p_uvlo_off)
    else $error("blocks active below lockout");
  property p_buck_b;
    (!gp_pin_b) [*4] |-> !sup_en[1];
  endproperty
  a_buck_b: assert property (p_buck_b)
    else $error("buck b on without its pin");
  property p_hw_reset;
    hold_cnt > DEGLITCH_CYC + 4 |-> !host_reset_output_n;
  endproperty
  a_hw_reset: assert property (p_hw_reset)
    else $error("host reset not driven during hardware reset");
  property p_soft_reset;
    reg_write && reg_addr == `PMSEQ_REG_CTRL && reg_wdata[0] && mode == `PMSEQ_ST_NORMAL
      |-> ##[1:6] !host_reset_output_n;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset gave no host reset");
endmodule // pmseq_chk
bind pmseq_top pmseq_chk #(.DEGLITCH_CYC(DEGLITCH_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .uvlo_ok_in(uvlo_ok_in), .hw_reset_in_n(hw_reset_in_n),
  .gp_pin_b(gp_pin_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .sup_en(sup_en), .pg_comp_en(pg_comp_en), .host_reset_output_n(host_reset_output_n),
  .int_oe(int_oe), .mode(mode)
);

// *** verif/pmseq_host.sv ***
// host processor model: register accesses over the plain port
// assumes it is called just after a rising edge; stays off the bus in reset
module pmseq_host (
  // clock and host reset
  input  logic        clk,
  input  logic        host_reset_output_n,
  // register port
  output logic [3:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_write,
  output logic        reg_read,
  input  logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int refused = 0;
  // idle bus at time zero
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // one write cycle, refused while the host is held in reset
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    if (!host_reset_output_n) refused++;
    else begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
    end
  endtask
  // one read cycle, data taken at the edge after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    d = 16'hDEAD;
    if (!host_reset_output_n) refused++;
    else begin
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
    end
  endtask
endmodule // pmseq_host

// *** verif/tb_pmseq_top.sv ***
// self-checking bench for the mode sequencer with a host model on the port
// assumes short timing parameters so every power-up finishes quickly
`include "pmseq_regs.vh"
module tb_pmseq_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, uvlo_ok_in = 0, rails_ok_in = 0, sys_sense_in = 0;
  logic thermal_fault_in = 0, hw_reset_in_n = 1, gp_pin_a = 1, gp_pin_b = 1;
  logic led_boost_ovp_in = 0, reg_write, reg_read, power_path_en, pg_comp_en;
  logic host_reset_output_n, int_out, int_oe;
  logic [7:0] sup_below_pg_in = 8'h00, other_status_in = 8'h00, sup_en;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd;
  logic [2:0] mode;
  int err_count = 0, n_tests = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  pmseq_top #(.SEQ_STEP_CYC(4), .DEGLITCH_CYC(8), .RESET_CYC(16)) uut (
    .clk(clk), .rst_n(rst_n), .uvlo_ok_in(uvlo_ok_in), .rails_ok_in(rails_ok_in),
    .sys_sense_in(sys_sense_in), .thermal_fault_in(thermal_fault_in),
    .hw_reset_in_n(hw_reset_in_n), .gp_pin_a(gp_pin_a), .gp_pin_b(gp_pin_b),
    .sup_below_pg_in(sup_below_pg_in), .led_boost_ovp_in(led_boost_ovp_in),
    .other_status_in(other_status_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .power_path_en(power_path_en), .sup_en(sup_en), .pg_comp_en(pg_comp_en),
    .host_reset_output_n(host_reset_output_n), .int_out(int_out), .int_oe(int_oe),
    .mode(mode));
  pmseq_host host (.clk(clk), .host_reset_output_n(host_reset_output_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait for a mode code
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 400 && mode !== m; i++) @(posedge clk);
    chk("mode", 16'(mode), 16'(m));
    if (mode !== m) summarize();
  endtask
  // main sequence
  initial begin
    tick(5);
    chk("reset_out", 16'(host_reset_output_n), 16'h0000);
    rst_n <= 1'b1;
    uvlo_ok_in <= 1'b1;
    rails_ok_in <= 1'b1;
    sup_below_pg_in <= 8'h10;
    wait_mode(`PMSEQ_ST_ENABLE);
    tick(20);
    chk("path", 16'(power_path_en), 16'h0001);
    chk("quiet", 16'({host_reset_output_n, int_oe, pg_comp_en}), 16'h0000);
    chk("held", 16'(mode), 16'(`PMSEQ_ST_ENABLE));
    sys_sense_in <= 1'b1;
    wait_mode(`PMSEQ_ST_SEQ);
    tick(1);
    chk("first_on", 16'(sup_en[3:0]), 16'h000B);
    wait_mode(`PMSEQ_ST_RESET);
    wait_mode(`PMSEQ_ST_NORMAL);
    tick(2);
    chk("reset_out", 16'(host_reset_output_n), 16'h0001);
    host.rd(`PMSEQ_REG_PG_MASK, rd);
    chk("pg_mask", rd, 16'h00FF);
    host.rd(`PMSEQ_REG_INT_MASK, rd);
    chk("int_mask", rd, 16'h0000);
    host.rd(`PMSEQ_REG_STATUS, rd);
    chk("status", rd, 16'h0006);
    host.rd(4'hF, rd);
    chk("unmapped", rd, 16'h0000);
    gp_pin_b <= 1'b0;
    tick(8);
    chk("buck_b", 16'(sup_en[1]), 16'h0000);
    gp_pin_b <= 1'b1;
    host.wr(`PMSEQ_REG_INT_FLAGS, 16'hFFFF);
    tick(3);
    chk("int_idle", 16'(int_oe), 16'h0000);
    other_status_in <= 8'h01;
    tick(8);
    chk("int_on", 16'(int_oe), 16'h0001);
    host.rd(`PMSEQ_REG_INT_FLAGS, rd);
    chk("flag0", 16'(rd[0]), 16'h0001);
    host.wr(`PMSEQ_REG_INT_MASK, 16'h0001);
    host.wr(`PMSEQ_REG_INT_FLAGS, 16'hFFFF);
    other_status_in <= 8'h00;
    tick(8);
    chk("int_masked", 16'(int_oe), 16'h0000);
    host.wr(`PMSEQ_REG_PG_MASK, 16'h00FE);
    host.wr(`PMSEQ_REG_CTRL, 16'h0001);
    wait_mode(`PMSEQ_ST_RESET);
    wait_mode(`PMSEQ_ST_NORMAL);
    host.rd(`PMSEQ_REG_PG_MASK, rd);
    chk("pg_mask_kept", rd, 16'h00FE);
    sup_below_pg_in <= 8'h11;
    wait_mode(`PMSEQ_ST_NOPOWER);
    wait_mode(`PMSEQ_ST_NORMAL);
    hw_reset_in_n <= 1'b0;
    tick(16);
    chk("hw_reset", 16'(host_reset_output_n), 16'h0000);
    hw_reset_in_n <= 1'b1;
    wait_mode(`PMSEQ_ST_NORMAL);
    thermal_fault_in <= 1'b1;
    wait_mode(`PMSEQ_ST_SLEEP);
    thermal_fault_in <= 1'b0;
    tick(30);
    chk("stuck", 16'({mode, sup_en}), 16'h0700);
    uvlo_ok_in <= 1'b0;
    wait_mode(`PMSEQ_ST_NOPOWER);
    uvlo_ok_in <= 1'b1;
    wait_mode(`PMSEQ_ST_NORMAL);
    host.wr(`PMSEQ_REG_CTRL, 16'h0040);
    wait_mode(`PMSEQ_ST_SLEEP);
    chk("int_out", 16'(int_out), 16'h0000);
    chk("refused", 16'(host.refused), 16'h0000);
    summarize();
  end
endmodule // tb_pmseq_top
